// ==== core/amo_regs.vh ====
`ifndef AMO_REGS_VH
`define AMO_REGS_VH
// Opcode matching, 14-bit instruction words
`define AMO_OP_WIDTH 14
`define AMO_DATA_WIDTH 8
`define AMO_ADDR_WIDTH 7
`define AMO_DIR_BIT 7
// Store accumulator: 00 0000 1fff ffff
`define AMO_STORE_MASK 14'h3F80
`define AMO_STORE_MATCH 14'h0080
// No-operation: 00 0000 0xx0 0000
`define AMO_NOP_MASK 14'h3F9F
`define AMO_NOP_MATCH 14'h0000
// OR accumulator with file: 00 0100 dfff ffff
`define AMO_IORF_MASK 14'h3F00
`define AMO_IORF_MATCH 14'h0400
// Increment file: 00 1010 dfff ffff
`define AMO_INC_MASK 14'h3F00
`define AMO_INC_MATCH 14'h0A00
// Load literal: 11 00xx kkkk kkkk
`define AMO_LDL_MASK 14'h3C00
`define AMO_LDL_MATCH 14'h3000
// OR literal: 11 1000 kkkk kkkk
`define AMO_IORL_MASK 14'h3F00
`define AMO_IORL_MATCH 14'h3800
`define AMO_ACCUM_RST 8'h00
`define AMO_ZERO_RST 1'h0
`endif

// ==== core/amo_core.v ====
`timescale 1ns/10ps
`include "amo_regs.vh"
module amo_core #(
  parameter DW = `AMO_DATA_WIDTH,
  parameter AW = `AMO_ADDR_WIDTH
) (
  input wire CLK, // Core clock
  input wire RST_N, // Async reset
  input wire [13:0] INSTR, // Fetched opcode
  input wire INSTR_VALID, // Opcode present this cycle
  input wire [DW-1:0] FILE_RDATA, // Data of addressed file register
  output wire [AW-1:0] FILE_ADDR, // File register address
  output reg [DW-1:0] FILE_WDATA, // Write data
  output reg FILE_WE, // File write strobe
  output wire [DW-1:0] ACCUM, // Accumulator
  output wire ZERO_FLAG, // Zero status
  output wire PC_ADVANCE, // Instruction retired
  output wire ILLEGAL_OP // Opcode outside the subset
);
  // Decoded operation classes, binary coded
  localparam [2:0] idle_op = 3'h0;
  localparam [2:0] store_accum_to_file_op = 3'h1;
  localparam [2:0] nop_op = 3'h2;
  localparam [2:0] increment_file_op = 3'h3;
  localparam [2:0] or_accum_with_file_op = 3'h4;
  localparam [2:0] load_literal_to_accum_op = 3'h5;
  localparam [2:0] or_literal_into_accum_op = 3'h6;
  localparam [2:0] unknown_op = 3'h7;

  reg [DW-1:0] accum_ff;
  reg [DW-1:0] nxt_accum;
  reg zero_ff;
  reg nxt_zero;
  reg [2:0] op_class;

  wire [DW-1:0] lit;
  wire dir;
  wire [DW-1:0] inc_sum;
  wire [DW-1:0] or_file;
  wire [DW-1:0] or_lit;

  // One decode strobe per opcode pattern
  wire is_store;
  wire is_nop;
  wire is_inc;
  wire is_or_file;
  wire is_load;
  wire is_or_lit;

  function hit;
    input [13:0] op;
    input [13:0] mask;
    input [13:0] match;
    begin
      hit = ((op & mask) == match);
    end
  endfunction

  function all_zero;
    input [DW-1:0] value;
    begin
      all_zero = (value == {DW{1'h0}});
    end
  endfunction

  assign lit = INSTR[DW-1:0];
  assign dir = INSTR[`AMO_DIR_BIT];
  // Wraps from all ones to zero, which then sets the zero flag
  assign inc_sum = FILE_RDATA + {{(DW-1){1'h0}}, 1'h1};
  assign or_file = accum_ff | FILE_RDATA;
  assign or_lit = accum_ff | lit;
  assign FILE_ADDR = INSTR[AW-1:0];

  // Opcode patterns do not overlap, so match order is free
  assign is_store = hit(INSTR, `AMO_STORE_MASK, `AMO_STORE_MATCH);
  assign is_nop = hit(INSTR, `AMO_NOP_MASK, `AMO_NOP_MATCH);
  assign is_inc = hit(INSTR, `AMO_INC_MASK, `AMO_INC_MATCH);
  assign is_or_file = hit(INSTR, `AMO_IORF_MASK, `AMO_IORF_MATCH);
  // Mask leaves out the two don't-care bits
  assign is_load = hit(INSTR, `AMO_LDL_MASK, `AMO_LDL_MATCH);
  assign is_or_lit = hit(INSTR, `AMO_IORL_MASK, `AMO_IORL_MATCH);

  always @* begin
    op_class = idle_op;
    if (!INSTR_VALID) begin
      op_class = idle_op;
    end else if (is_store) begin
      op_class = store_accum_to_file_op;
    end else if (is_nop) begin
      op_class = nop_op;
    end else if (is_inc) begin
      op_class = increment_file_op;
    end else if (is_or_file) begin
      op_class = or_accum_with_file_op;
    end else if (is_load) begin
      op_class = load_literal_to_accum_op;
    end else if (is_or_lit) begin
      op_class = or_literal_into_accum_op;
    end else begin
      op_class = unknown_op;
    end
  end

  // File write lands at the edge that retires the opcode
  always @* begin
    FILE_WE = 1'h0;
    FILE_WDATA = {DW{1'h0}};
    case (op_class)
      store_accum_to_file_op: begin
        FILE_WE = 1'h1;
        FILE_WDATA = accum_ff;
      end
      increment_file_op: begin
        FILE_WE = dir;
        FILE_WDATA = dir ? inc_sum : {DW{1'h0}};
      end
      or_accum_with_file_op: begin
        FILE_WE = dir;
        FILE_WDATA = dir ? or_file : {DW{1'h0}};
      end
      nop_op: begin
        FILE_WE = 1'h0;
        FILE_WDATA = {DW{1'h0}};
      end
      default: begin
        FILE_WE = 1'h0;
        FILE_WDATA = {DW{1'h0}};
      end
    endcase
  end

  // Accumulator next value
  always @* begin
    nxt_accum = accum_ff;
    case (op_class)
      increment_file_op: begin
        if (!dir) begin
          nxt_accum = inc_sum;
        end
      end
      or_accum_with_file_op: begin
        if (!dir) begin
          nxt_accum = or_file;
        end
      end
      load_literal_to_accum_op: begin
        nxt_accum = lit;
      end
      or_literal_into_accum_op: begin
        nxt_accum = or_lit;
      end
      store_accum_to_file_op: begin
        nxt_accum = accum_ff;
      end
      nop_op: begin
        nxt_accum = accum_ff;
      end
      default: begin
        nxt_accum = accum_ff;
      end
    endcase
  end

  // Store, load and no-op hold the zero flag
  always @* begin
    nxt_zero = zero_ff;
    case (op_class)
      increment_file_op: begin
        nxt_zero = all_zero(inc_sum);
      end
      or_accum_with_file_op: begin
        nxt_zero = all_zero(or_file);
      end
      or_literal_into_accum_op: begin
        nxt_zero = all_zero(or_lit);
      end
      store_accum_to_file_op: begin
        nxt_zero = zero_ff;
      end
      load_literal_to_accum_op: begin
        nxt_zero = zero_ff;
      end
      nop_op: begin
        nxt_zero = zero_ff;
      end
      default: begin
        nxt_zero = zero_ff;
      end
    endcase
  end

  // Plain asynchronous clear; RST_N release is not synchronised here, so its source owns the release timing
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      accum_ff <= `AMO_ACCUM_RST;
    end else begin
      accum_ff <= nxt_accum;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      zero_ff <= `AMO_ZERO_RST;
    end else begin
      zero_ff <= nxt_zero;
    end
  end

  assign ACCUM = accum_ff;
  assign ZERO_FLAG = zero_ff;
  // Every opcode of the subset retires in one cycle
  assign PC_ADVANCE = (op_class != idle_op) & (op_class != unknown_op);
  // Unknown opcodes are dropped; no register or flag moves
  assign ILLEGAL_OP = (op_class == unknown_op);
endmodule // amo_core

// ==== verification/amo_chk_assertions.sv ====
`timescale 1ns/10ps
module amo_chk (
  input wire CLK, // clk
  input wire RST_N, // rst
  input wire [13:0] INSTR, // op
  input wire INSTR_VALID, // vld
  input wire [7:0] FILE_RDATA, // rd
  input wire [6:0] FILE_ADDR, // ad
  input wire [7:0] FILE_WDATA, // wd
  input wire FILE_WE, // we
  input wire [7:0] ACCUM, // acc
  input wire ZERO_FLAG, // z
  input wire PC_ADVANCE, // pc
  input wire ILLEGAL_OP // Unknown opcode
);
  wire v = INSTR_VALID;
  wire [5:0] hi = INSTR[13:8];
  wire [7:0] lit = INSTR[7:0];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_INC_W: assert property (v && hi == 6'h0A && !INSTR[7]
    |=> ACCUM == $past(FILE_RDATA) + 8'h01)
    else $error("inc to accum");
  AST_INC_F: assert property (v && hi == 6'h0A && INSTR[7]
    |-> FILE_WE && FILE_WDATA == FILE_RDATA + 8'h01)
    else $error("inc to file");
  AST_ORF: assert property (v && hi == 6'h04 && !INSTR[7]
    |=> ACCUM == ($past(ACCUM) | $past(FILE_RDATA)) && ZERO_FLAG == (ACCUM == 8'h00))
    else $error("or file");
  AST_ORF_F: assert property (v && hi == 6'h04 && INSTR[7]
    |-> FILE_WE && FILE_WDATA == (ACCUM | FILE_RDATA)
    ##1 $stable(ACCUM) && ZERO_FLAG == ($past(FILE_WDATA) == 8'h00))
    else $error("or file to file");
  AST_ORL: assert property (v && hi == 6'h38
    |=> ACCUM == ($past(ACCUM) | $past(lit)) && ZERO_FLAG == (ACCUM == 8'h00))
    else $error("or literal");
  AST_STO: assert property (v && INSTR[13:7] == 7'h01
    |-> FILE_WE && FILE_WDATA == ACCUM && FILE_ADDR == INSTR[6:0]
    ##1 $stable(ZERO_FLAG) && $stable(ACCUM))
    else $error("store");
  AST_LDL: assert property (v && INSTR[13:10] == 4'hC
    |=> ACCUM == $past(lit) && $stable(ZERO_FLAG) && $past(PC_ADVANCE))
    else $error("load");
  AST_NOP: assert property (v && (INSTR & 14'h3F9F) == 14'h0000
    |-> PC_ADVANCE && !FILE_WE ##1 $stable(ACCUM) && $stable(ZERO_FLAG))
    else $error("nop");
  AST_ILL: assert property (ILLEGAL_OP
    |-> !PC_ADVANCE && !FILE_WE ##1 $stable(ACCUM) && $stable(ZERO_FLAG))
    else $error("unknown opcode");
endmodule // amo_chk

// ==== verification/tb_amo_core.sv ====
`timescale 1ns/10ps
module tb_amo_core;
  reg CLK = 1'b0;
  reg RST_N = 1'b0;
  reg [13:0] INSTR = 14'h0000;
  reg INSTR_VALID = 1'b0;
  reg [7:0] file_mem [0:127];
  wire [6:0] FILE_ADDR;
  wire [7:0] FILE_WDATA, ACCUM;
  wire FILE_WE, ZERO_FLAG, PC_ADVANCE, ILLEGAL_OP;
  integer errors = 0, samples_checked = 0, k;
  always #5 CLK = ~CLK;
  always @(posedge CLK) if (FILE_WE) file_mem[FILE_ADDR] <= FILE_WDATA;
  amo_core amo_core_inst (.CLK(CLK), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
    .FILE_RDATA(file_mem[FILE_ADDR]), .FILE_ADDR(FILE_ADDR), .FILE_WDATA(FILE_WDATA),
    .FILE_WE(FILE_WE), .ACCUM(ACCUM), .ZERO_FLAG(ZERO_FLAG), .PC_ADVANCE(PC_ADVANCE),
    .ILLEGAL_OP(ILLEGAL_OP));
  task chk(input [7:0] s, input [7:0] e); begin
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  end endtask
  // Leaves valid high so instructions run back to back
  task ex(input [13:0] op); begin
    INSTR = op;
    INSTR_VALID = 1'b1;
    #1;
    chk({6'h00, PC_ADVANCE, ILLEGAL_OP}, 8'h02);
    @(posedge CLK);
    #1;
  end endtask
  task t_load; begin
    for (k = 0; k < 4; k = k + 1) begin
      ex({4'hC, k[1:0], 8'h5A});
      chk(ACCUM, 8'h5A);
    end
    chk({7'h00, ZERO_FLAG}, 8'h00);
  end endtask
  task t_store_inc; begin
    ex(14'h00A1);
    chk(file_mem[33], 8'h5A);
    ex(14'h0AA1);
    chk(file_mem[33], 8'h5B);
    ex(14'h0A21);
    chk(ACCUM, 8'h5C);
  end endtask
  task t_or_nop; begin
    ex(14'h3000);
    ex(14'h3800);
    chk({7'h00, ZERO_FLAG}, 8'h01);
    ex(14'h3881);
    chk(ACCUM, 8'h81);
    chk({7'h00, ZERO_FLAG}, 8'h00);
    ex(14'h04A1);
    chk(file_mem[33], 8'hDB);
    chk(ACCUM, 8'h81);
    ex(14'h0421);
    chk(ACCUM, 8'hDB);
    ex(14'h0060);
    chk(ACCUM, 8'hDB);
  end endtask
  // Opcode just outside the no-operation pattern must be dropped
  task t_illegal; begin
    INSTR = 14'h0009;
    INSTR_VALID = 1'b1;
    #1;
    chk({6'h00, PC_ADVANCE, ILLEGAL_OP}, 8'h01);
    @(posedge CLK);
    #1;
    chk(ACCUM, 8'hDB);
    INSTR_VALID = 1'b0;
  end endtask
  task test_done; begin
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end endtask
  initial begin
    repeat (3) @(posedge CLK);
    #1 RST_N = 1'b1;
    t_load;
    t_store_inc;
    t_or_nop;
    t_illegal;
    test_done;
  end
endmodule // tb_amo_core
bind amo_core amo_chk amo_chk_inst (.CLK(CLK), .RST_N(RST_N), .INSTR(INSTR),
  .INSTR_VALID(INSTR_VALID), .FILE_RDATA(FILE_RDATA), .FILE_ADDR(FILE_ADDR),
  .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE), .ACCUM(ACCUM), .ZERO_FLAG(ZERO_FLAG),
  .PC_ADVANCE(PC_ADVANCE), .ILLEGAL_OP(ILLEGAL_OP));
